// ==== rtl/clk_mode_pkg.sv ====
// Purpose: Shared constants and types for the system clock mode control
// Assumes: One register word on APB, oscillators seen as toggling inputs
// Notes: Ready thresholds are counted in oscillator cycles, not pclk
package clk_mode_pkg;

    // ==========================================================
    // Register map and field layout
    // ==========================================================
    localparam logic [7:0] SMC_OFFSET = 8'h00;
    localparam logic [7:0] SMC_RESET = 8'h03;
    localparam int SEL_BIT = 0;
    localparam int IDLE_BIT = 1;
    localparam int HRDY_BIT = 2;
    localparam int LRDY_BIT = 3;
    localparam int FAST_BIT = 4;
    localparam int DIV_LSB = 5;
    localparam logic [2:0] DIV_FIRST_HIGH = 3'h2;
    localparam logic [5:0] DIV_MASK_MAX = 6'h3f;

    // ==========================================================
    // Oscillator settling counts, in oscillator cycles, and watchdog prescaler last count
    // ==========================================================
    localparam logic [10:0] CRYSTAL_STABLE_CYCLES = 11'h400;
    localparam logic [10:0] FAST_RC_STABLE_CYCLES = 11'h010;
    localparam logic [10:0] SLOW_RC_STABLE_CYCLES = 11'h002;
    localparam logic [1:0] WDT_SYS_DIV_LAST = 2'h3;

    // ==========================================================
    // Types
    // ==========================================================
    // High speed oscillator type, fixed by configuration option
    typedef enum logic [1:0] {
        HOSC_CRYSTAL,
        HOSC_EXT_RC,
        HOSC_INT_RC
    } high_osc_type_e;

    typedef enum {
        MODE_RUN,
        MODE_IDLE_CLOCK_STOPPED,
        MODE_IDLE_CLOCK_RUNNING,
        MODE_LIGHT_SLEEP,
        MODE_DEEP_SLEEP
    } power_mode_e;

    // Static configuration options
    typedef struct packed {
        high_osc_type_e high_type;
        logic low_sys_is_slow_rc;
        logic sub_is_slow_rc;
        logic tbc_is_slow_rc;
        logic wdt_from_sub;
    } osc_cfg_s;

    // Clock enable pulses handed to consumers
    typedef struct packed {
        logic cpu;
        logic system_clock;
        logic substitute_clock;
        logic time_base_clock;
        logic watchdog_clock;
    } clk_en_s;

endpackage

// ==== rtl/system_clock_mode_control.sv ====
// Purpose: Clock selection, divider and halt mode control with APB access
// Assumes: Oscillators arrive as free toggling pins sampled on pclk
// Notes: Every derived clock is a one-pclk enable pulse per source edge or per divider tick
`timescale 1ns/1ps
`default_nettype none

// Function
// - High speed source type is a fixed option: crystal, external or internal RC.
// - Low speed system clock is crystal or slow RC by option.
// - Substitute and time base clocks each pick a low oscillator by option.
// - Time base clock feeds timers; watchdog uses system/4 or substitute.
// - Select bit set routes the undivided high speed clock.
// - Divider field 000/001 low speed, 010..111 high divided 64 to 2.
// - Moving to low speed clock stops the high speed oscillator.
// - In both run modes CPU and all peripheral clocks are active.
// - Deep sleep stops every clock and disables the watchdog.
// - Deep sleep needs voltage detector off; else it is not entered.
// - Light sleep keeps substitute clock, watchdog clock only when fed from substitute, stops time base.
// - Idle with system clock off stops CPU, system clock and high speed oscillator.
// - In that idle mode watchdog clock runs only from substitute clock.
// - Idle with system clock on keeps selected oscillator for peripherals.
// - Idle enable bit picks idle or sleep on halt.
// - Fast wakeup runs from substitute clock until crystal is ready.
// - Low ready flag clears in deep sleep, rises after settling count.
// - High ready flag clears when stopped, rises after settling count.
// - High ready is set before the CPU first runs after power-on.
module system_clock_mode_control #(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire clk_mode_pkg::osc_cfg_s osc_cfg,
    input wire logic high_osc_in,
    input wire logic low_crystal_in,
    input wire logic slow_rc_in,
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic sysclk_on_in_idle,
    input wire logic watchdog_enable,
    input wire logic low_voltage_detect_enable,
    output clk_mode_pkg::clk_en_s clk_en,
    output logic high_osc_enable,
    output logic low_osc_enable,
    output logic watchdog_disable,
    output logic cpu_halted
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 8 and 32");
    end

    // ==========================================================
    // Decoding helpers
    // ==========================================================
    // Selection {select bit, divider field} names the low clock
    function automatic logic sel_is_low(input logic [3:0] sel);
        return !sel[3] && (sel[2:1] == 2'b00);
    endfunction

    // Mask of divider counter bits that must be all ones for a tick
    function automatic logic [5:0] sel_mask(input logic [3:0] sel);
        logic [2:0] sh;
        sh = sel[2:0] - clk_mode_pkg::DIV_FIRST_HIGH;
        return sel[3] ? 6'h00 : (clk_mode_pkg::DIV_MASK_MAX >> sh);
    endfunction

    // ==========================================================
    // Oscillator pin synchronisers and edge ticks
    // ==========================================================
    logic [2:0] osc_pin;
    logic [2:0] osc_tick;
    assign osc_pin = {slow_rc_in, low_crystal_in, high_osc_in};

    for (genvar i = 0; i < 3; i++) begin : g_osc
        logic meta_q;
        logic sync_q;
        logic last_q;
        // Two stages, then a third for the rising edge
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                meta_q <= 1'b0;
                sync_q <= 1'b0;
                last_q <= 1'b0;
            end else if (ce) begin
                meta_q <= osc_pin[i];
                sync_q <= meta_q;
                last_q <= sync_q;
            end
        end
        assign osc_tick[i] = sync_q && !last_q;
    end

    // Source routing by configuration option
    logic hi_tick;
    logic low_tick;
    logic sub_tick;
    logic tbc_tick;
    logic hi_is_crystal;
    assign hi_tick = osc_tick[0];
    assign hi_is_crystal = osc_cfg.high_type == clk_mode_pkg::HOSC_CRYSTAL;
    assign low_tick = osc_cfg.low_sys_is_slow_rc ? osc_tick[2]
                                                 : osc_tick[1];
    assign sub_tick = osc_cfg.sub_is_slow_rc ? osc_tick[2]
                                             : osc_tick[1];
    assign tbc_tick = osc_cfg.tbc_is_slow_rc ? osc_tick[2]
                                             : osc_tick[1];

    // ==========================================================
    // Control register and APB slave
    // ==========================================================
    logic [3:0] req_sel_q;
    logic idle_on_halt_enable_q;
    logic fast_wakeup_enable_q;
    logic high_osc_ready_q;
    logic low_osc_ready_q;
    logic [7:0] smc_rd;
    logic addr_hit;
    logic setup_ph;
    logic wr_acc;
    assign addr_hit = paddr == ADDR_W'(clk_mode_pkg::SMC_OFFSET);
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pready && pwrite && addr_hit;
    assign smc_rd = {req_sel_q[2:0], fast_wakeup_enable_q, low_osc_ready_q,
                     high_osc_ready_q, idle_on_halt_enable_q, req_sel_q[3]};

    // Zero wait: answer prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= setup_ph;
            pslverr <= setup_ph && !addr_hit;
            prdata <= (setup_ph && addr_hit && !pwrite) ? {24'h0, smc_rd}
                                                        : 32'h0;
        end
    end

    // Writable fields; ready flags are read only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_sel_q <= {clk_mode_pkg::SMC_RESET[clk_mode_pkg::SEL_BIT],
                          clk_mode_pkg::SMC_RESET[7:5]};
            idle_on_halt_enable_q <=
                clk_mode_pkg::SMC_RESET[clk_mode_pkg::IDLE_BIT];
            fast_wakeup_enable_q <=
                clk_mode_pkg::SMC_RESET[clk_mode_pkg::FAST_BIT];
        end else if (ce && wr_acc) begin
            req_sel_q <= {pwdata[clk_mode_pkg::SEL_BIT],
                          pwdata[clk_mode_pkg::DIV_LSB +: 3]};
            idle_on_halt_enable_q <= pwdata[clk_mode_pkg::IDLE_BIT];
            fast_wakeup_enable_q <= pwdata[clk_mode_pkg::FAST_BIT];
        end
    end

    // ==========================================================
    // Power mode state machine
    // ==========================================================
    clk_mode_pkg::power_mode_e mode_q;
    clk_mode_pkg::power_mode_e mode_d;
    logic sleep_keeps_sub;
    logic halt_now;
    logic wake_now;
    assign sleep_keeps_sub = low_voltage_detect_enable
        || (watchdog_enable && osc_cfg.wdt_from_sub);
    assign halt_now = halt_req && mode_q == clk_mode_pkg::MODE_RUN;
    assign wake_now = wake_req && mode_q != clk_mode_pkg::MODE_RUN;

    // Halt outcome and wake return
    always_comb begin
        mode_d = mode_q;
        unique case (mode_q)
            clk_mode_pkg::MODE_RUN: begin
                if (halt_req && idle_on_halt_enable_q) begin
                    mode_d = sysclk_on_in_idle
                        ? clk_mode_pkg::MODE_IDLE_CLOCK_RUNNING
                        : clk_mode_pkg::MODE_IDLE_CLOCK_STOPPED;
                end else if (halt_req) begin
                    mode_d = sleep_keeps_sub
                        ? clk_mode_pkg::MODE_LIGHT_SLEEP
                        : clk_mode_pkg::MODE_DEEP_SLEEP;
                end
            end
            clk_mode_pkg::MODE_IDLE_CLOCK_STOPPED,
            clk_mode_pkg::MODE_IDLE_CLOCK_RUNNING,
            clk_mode_pkg::MODE_LIGHT_SLEEP,
            clk_mode_pkg::MODE_DEEP_SLEEP: begin
                if (wake_req) begin
                    mode_d = clk_mode_pkg::MODE_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= clk_mode_pkg::MODE_RUN;
        end else if (ce) begin
            mode_q <= mode_d;
        end
    end

    // Mode groupings
    logic hi_stop_mode;
    logic sys_on;
    logic deep;
    assign deep = mode_q == clk_mode_pkg::MODE_DEEP_SLEEP;
    assign hi_stop_mode = mode_q == clk_mode_pkg::MODE_IDLE_CLOCK_STOPPED
        || mode_q == clk_mode_pkg::MODE_LIGHT_SLEEP || deep;
    assign sys_on = mode_q == clk_mode_pkg::MODE_RUN
        || mode_q == clk_mode_pkg::MODE_IDLE_CLOCK_RUNNING;

    // ==========================================================
    // Source switching and divider
    // ==========================================================
    logic [3:0] act_sel_q;
    logic [5:0] div_cnt_q;
    logic [5:0] act_mask;
    logic act_low;
    logic raw_tick;
    logic raw_ready;
    logic take_sel;
    assign act_low = sel_is_low(act_sel_q);
    assign act_mask = sel_mask(act_sel_q);
    assign raw_tick = act_low ? low_tick
        : hi_tick && ((div_cnt_q & act_mask) == act_mask);
    assign raw_ready = act_low ? low_osc_ready_q : high_osc_ready_q;
    // Switch only on the old source's tick or while it is silent
    assign take_sel = act_sel_q != req_sel_q
        && (raw_tick || !raw_ready);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_sel_q <= {clk_mode_pkg::SMC_RESET[clk_mode_pkg::SEL_BIT],
                          clk_mode_pkg::SMC_RESET[7:5]};
            div_cnt_q <= 6'h00;
        end else if (ce) begin
            if (take_sel) begin
                act_sel_q <= req_sel_q;
                div_cnt_q <= 6'h00;
            end else if (hi_tick) begin
                div_cnt_q <= div_cnt_q + 6'h01;
            end
        end
    end

    // Fast wakeup: substitute clock stands in until crystal settles
    logic fast_sub_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_sub_q <= 1'b0;
        end else if (ce) begin
            if (wake_now && fast_wakeup_enable_q && hi_is_crystal && !act_low
                && !deep && mode_q != clk_mode_pkg::MODE_IDLE_CLOCK_RUNNING)
            begin
                fast_sub_q <= 1'b1;
            end else if (high_osc_ready_q || act_low) begin
                fast_sub_q <= 1'b0;
            end
        end
    end

    logic sys_tick;
    logic src_ready;
    assign sys_tick = fast_sub_q ? sub_tick : raw_tick;
    assign src_ready = fast_sub_q ? low_osc_ready_q : raw_ready;

    // ==========================================================
    // Oscillator enables and ready counters
    // ==========================================================
    logic hi_wanted;
    logic [10:0] hi_cnt_q;
    logic [10:0] lo_cnt_q;
    logic [10:0] hi_target;
    logic [10:0] lo_target;
    assign hi_wanted = !(sel_is_low(req_sel_q) && act_low);
    assign hi_target = hi_is_crystal ? clk_mode_pkg::CRYSTAL_STABLE_CYCLES
                                     : clk_mode_pkg::FAST_RC_STABLE_CYCLES;
    assign lo_target = osc_cfg.low_sys_is_slow_rc
        ? clk_mode_pkg::SLOW_RC_STABLE_CYCLES
        : clk_mode_pkg::CRYSTAL_STABLE_CYCLES;

    // Enables follow the current mode, one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_osc_enable <= 1'b0;
            low_osc_enable <= 1'b0;
        end else if (ce) begin
            high_osc_enable <= hi_wanted && !hi_stop_mode;
            low_osc_enable <= !deep;
        end
    end

    // High ready: counts high edges while the oscillator runs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt_q <= 11'h000;
            high_osc_ready_q <= 1'b0;
        end else if (ce) begin
            if (!high_osc_enable) begin
                hi_cnt_q <= 11'h000;
                high_osc_ready_q <= 1'b0;
            end else if (hi_tick && !high_osc_ready_q) begin
                hi_cnt_q <= hi_cnt_q + 11'h001;
                high_osc_ready_q <= hi_cnt_q == hi_target - 11'h001;
            end
        end
    end

    // Low ready: counts low edges, cleared in deep sleep
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lo_cnt_q <= 11'h000;
            low_osc_ready_q <= 1'b0;
        end else if (ce) begin
            if (!low_osc_enable) begin
                lo_cnt_q <= 11'h000;
                low_osc_ready_q <= 1'b0;
            end else if (low_tick && !low_osc_ready_q) begin
                lo_cnt_q <= lo_cnt_q + 11'h001;
                low_osc_ready_q <= lo_cnt_q == lo_target - 11'h001;
            end
        end
    end

    // ==========================================================
    // Clock enable outputs
    // ==========================================================
    logic [1:0] wdt_div_q;
    logic sys_en_d;
    logic sub_en_d;
    assign sys_en_d = sys_on && src_ready && sys_tick;
    assign sub_en_d = !deep && sub_tick;

    // Watchdog prescaler on system clock pulses
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_div_q <= 2'h0;
        end else if (ce && sys_en_d) begin
            wdt_div_q <= wdt_div_q + 2'h1;
        end
    end

    // CPU waits for its source, so it never runs before ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_en <= '0;
            watchdog_disable <= 1'b0;
            cpu_halted <= 1'b0;
        end else if (ce) begin
            clk_en.cpu <= mode_q == clk_mode_pkg::MODE_RUN
                && src_ready && sys_tick;
            clk_en.system_clock <= sys_en_d;
            clk_en.substitute_clock <= sub_en_d;
            clk_en.time_base_clock <= tbc_tick && !deep
                && mode_q != clk_mode_pkg::MODE_LIGHT_SLEEP;
            clk_en.watchdog_clock <= !deep && (osc_cfg.wdt_from_sub
                ? sub_en_d
                : sys_en_d && wdt_div_q == clk_mode_pkg::WDT_SYS_DIV_LAST);
            watchdog_disable <= deep;
            cpu_halted <= mode_q != clk_mode_pkg::MODE_RUN;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    property p_hi_off_in_slow;
        @(posedge pclk) disable iff (!presetn)
        ce && act_low && sel_is_low(req_sel_q) |=> !high_osc_enable;
    endproperty
    a_hi_off_in_slow: assert property (p_hi_off_in_slow)
        else $error("High oscillator left on in slow mode");

    property p_deep_all_off;
        @(posedge pclk) disable iff (!presetn)
        ce && deep ##1 ce && deep |=> clk_en == '0 && watchdog_disable;
    endproperty
    a_deep_all_off: assert property (p_deep_all_off)
        else $error("Clock running in deep sleep");

    property p_lvd_blocks_deep;
        @(posedge pclk) disable iff (!presetn)
        ce && halt_now && !idle_on_halt_enable_q && low_voltage_detect_enable
        |=> mode_q == clk_mode_pkg::MODE_LIGHT_SLEEP;
    endproperty
    a_lvd_blocks_deep: assert property (p_lvd_blocks_deep)
        else $error("Deep sleep entered with voltage detector on");

    property p_light_no_tbc;
        @(posedge pclk) disable iff (!presetn)
        ce && mode_q == clk_mode_pkg::MODE_LIGHT_SLEEP
        |=> !clk_en.time_base_clock && !clk_en.cpu;
    endproperty
    a_light_no_tbc: assert property (p_light_no_tbc)
        else $error("Time base running in light sleep");

    property p_idle_stop_entry;
        @(posedge pclk) disable iff (!presetn)
        ce && halt_now && idle_on_halt_enable_q && !sysclk_on_in_idle
        |=> mode_q == clk_mode_pkg::MODE_IDLE_CLOCK_STOPPED
            ##1 !high_osc_enable;
    endproperty
    a_idle_stop_entry: assert property (p_idle_stop_entry)
        else $error("Idle with stopped clock not entered");

    property p_idle_stop_wdt;
        @(posedge pclk) disable iff (!presetn)
        ce && mode_q == clk_mode_pkg::MODE_IDLE_CLOCK_STOPPED
        && !osc_cfg.wdt_from_sub |=> !clk_en.watchdog_clock;
    endproperty
    a_idle_stop_wdt: assert property (p_idle_stop_wdt)
        else $error("Watchdog clock from system clock in stopped idle");

    property p_sleep_on_halt;
        @(posedge pclk) disable iff (!presetn)
        ce && halt_now && !idle_on_halt_enable_q
        |=> mode_q inside {clk_mode_pkg::MODE_LIGHT_SLEEP,
                           clk_mode_pkg::MODE_DEEP_SLEEP};
    endproperty
    a_sleep_on_halt: assert property (p_sleep_on_halt)
        else $error("Halt with idle disabled did not sleep");

    property p_low_ready_deep;
        @(posedge pclk) disable iff (!presetn)
        ce && deep ##1 ce |=> !low_osc_ready_q;
    endproperty
    a_low_ready_deep: assert property (p_low_ready_deep)
        else $error("Low ready set in deep sleep");

    property p_hi_ready_stop;
        @(posedge pclk) disable iff (!presetn)
        ce && hi_stop_mode ##1 ce |=> !high_osc_ready_q;
    endproperty
    a_hi_ready_stop: assert property (p_hi_ready_stop)
        else $error("High ready set while oscillator stopped");

    property p_cpu_only_run;
        @(posedge pclk) disable iff (!presetn)
        clk_en.cpu |-> $past(mode_q == clk_mode_pkg::MODE_RUN)
            && $past(src_ready);
    endproperty
    a_cpu_only_run: assert property (p_cpu_only_run)
        else $error("CPU clocked outside run or before ready");

endmodule

`default_nettype wire

// ==== sim/osc_consumer_model.sv ====
// Purpose: Oscillator pins and clock consumer model
// Assumes: Pins toggle no faster than pclk/4
// Notes: A stopped oscillator holds its pin low
`timescale 1ns/1ps
`default_nettype none
module osc_consumer_model (
    input wire logic pclk,
    input wire logic high_osc_enable,
    input wire logic low_osc_enable,
    input wire clk_mode_pkg::clk_en_s clk_en,
    input wire logic clr,
    output logic high_osc_in,
    output logic low_crystal_in,
    output logic slow_rc_in,
    output logic [4:0] seen,
    output logic [15:0] n_sys
);
    logic [3:0] ph_q = 4'h0;
    // ====
    // Oscillators, still while disabled
    assign high_osc_in = high_osc_enable & ph_q[1];
    assign slow_rc_in = low_osc_enable & ph_q[2];
    assign low_crystal_in = low_osc_enable & ph_q[3];
    // Consumers note which enables pulsed
    always @(posedge pclk) begin
        ph_q <= ph_q + 4'h1;
        seen <= clr ? 5'h00 : (seen | 5'(clk_en));
        n_sys <= clr ? 16'h0 : n_sys + {15'h0, clk_en.system_clock};
    end
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the clock mode control
// Assumes: Internal RC high source, slow RC for low clocks
// Notes: Enable pulses are judged through the consumer model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, clr = 1'b1, halt_req = 1'b0, wake_req = 1'b0;
    logic sys_on = 1'b0, wdt_en = 1'b0, lvd_en = 1'b0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, hi_in, lx_in, rc_in, hi_en, lo_en, wd_off, halted;
    logic [4:0] seen;
    logic [15:0] n_sys;
    clk_mode_pkg::clk_en_s clk_en;
    int n_mismatch = 0, n_tests = 0;
    localparam clk_mode_pkg::osc_cfg_s cfg =
        '{clk_mode_pkg::HOSC_INT_RC, 1'b1, 1'b1, 1'b1, 1'b1};
    logic [16:0] row [5] = '{{4'h0, 5'h00, 8'h01}, {4'h2, 5'h05, 8'h09},
        {4'h1, 5'h05, 8'h09}, {4'h8, 5'h07, 8'h0b}, {4'hc, 5'h0f, 8'h0f}};
    system_clock_mode_control i_dut (.pclk(pclk), .presetn(presetn),
        .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_cfg(cfg), .high_osc_in(hi_in),
        .low_crystal_in(lx_in), .slow_rc_in(rc_in), .halt_req(halt_req),
        .wake_req(wake_req), .sysclk_on_in_idle(sys_on),
        .watchdog_enable(wdt_en), .low_voltage_detect_enable(lvd_en),
        .clk_en(clk_en), .high_osc_enable(hi_en), .low_osc_enable(lo_en),
        .watchdog_disable(wd_off), .cpu_halted(halted));
    osc_consumer_model i_osc (.pclk(pclk), .high_osc_enable(hi_en),
        .low_osc_enable(lo_en), .clk_en(clk_en), .clr(clr),
        .high_osc_in(hi_in), .low_crystal_in(lx_in), .slow_rc_in(rc_in),
        .seen(seen), .n_sys(n_sys));
    // ====
    // Clock and watchdog
    initial forever #2.5 pclk = ~pclk;
    initial begin
        #400000;
        n_mismatch++;
        end_sim();
    end
    // ====
    // Shared tasks
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= wr;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic step(input logic h);
        @(posedge pclk);
        halt_req <= h;
        wake_req <= ~h;
        @(posedge pclk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
    endtask
    task automatic watch(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ====
    // Scenarios
    task automatic t_reg();
        apb(1'b0, 8'h00, 32'h0);
        chk("reset value", 32'h03, rd);
        repeat (200) @(posedge pclk);
        apb(1'b0, 8'h00, 32'h0);
        chk("ready flags", 32'h0f, rd);
        apb(1'b1, 8'h00, 32'hf0);
        apb(1'b0, 8'h00, 32'h0);
        chk("read-only flags", 32'hfc, rd);
        apb(1'b1, 8'h04, 32'hff);
        chk("unmapped error", 32'h1, {31'h0, err});
        $display("t_reg done");
    endtask
    task automatic t_div();
        logic [31:0] e, g;
        for (int k = 0; k < 9; k++) begin
            apb(1'b1, 8'h00, (k == 8) ? 32'h03 : {24'h0, k[2:0], 5'h02});
            e = (k < 2) ? 32'd128 : 32'd256 >> (8 - k);
            repeat (200) @(posedge pclk);
            watch(1024);
            g = {16'h0, n_sys};
            if (g == e + 1 || g + 1 == e) g = e;
            chk("system pulses", e, g);
            chk("run enables", 32'h1f, {27'h0, seen});
            if (k < 2) chk("high osc off", 32'h0, {31'h0, hi_en});
        end
        $display("t_div done");
    endtask
    task automatic t_halt();
        logic [16:0] r;
        for (int i = 0; i < 5; i++) begin
            r = row[i];
            apb(1'b1, 8'h00, {30'h0, r[16], 1'b1});
            sys_on <= r[15];
            lvd_en <= r[14];
            wdt_en <= r[13];
            step(1'b1);
            repeat (100) @(posedge pclk);
            chk("halted", 32'h1, {31'h0, halted});
            watch(256);
            chk("mode enables", r[12:8], seen);
            chk("wdt disabled", r[16:13] == 0, wd_off);
            apb(1'b0, 8'h00, 32'h0);
            chk("halt flags", r[7:0], rd);
            step(1'b0);
            repeat (300) @(posedge pclk);
            chk("woken", 32'h0, {31'h0, halted});
        end
        $display("t_halt done");
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reg();
        t_div();
        t_halt();
        end_sim();
    end
endmodule
`default_nettype wire
